// file: design/hprx_pkg.sv
// Shared constants and types for the host port and receive outputs
package hprx_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int SRC_W = 6;
  // Register addresses of the small internal map
  localparam logic [7:0] CTRL_THREE_ADDR = 8'h03;
  localparam logic [7:0] STATUS_ADDR = 8'h10;
  localparam logic [7:0] CLEAR_ADDR = 8'h11;
  localparam logic [7:0] PEND_ADDR = 8'h12;
  // Field positions
  localparam int CTRL_EDGE_BIT = 0;
  localparam int CTRL_UNIPOLAR_BIT = 1;
  localparam int SRC_NOSIG = 0;
  localparam int SRC_ALARM = 1;
  localparam int SRC_PRTP = 2;
  localparam int SRC_DSHORT = 3;
  localparam int SRC_DOPEN = 4;
  localparam int SRC_ESTORE = 5;
  // Reset values
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] CLEAR_RST = 8'h00;
  localparam logic [7:0] RDATA_RST = 8'h00;
  // Host phase counter load; the strobe lasts one core clock more than this
  localparam int STROBE_CYC = 4;
  localparam logic [2:0] STROBE_CNT = 3'(STROBE_CYC);
  typedef enum logic {HPRX_SEP_STROBE, HPRX_DIR_LINE} hprx_style_t;
endpackage : hprx_pkg

// file: design/hprx_bus_if.sv
// Multiplexed host bus between host and transceiver
`timescale 1ns/1ps
interface hprx_bus_if;
  logic ale;
  logic rd_n;
  logic wr_n;
  logic cs_n;
  logic [7:0] ad_host_o;
  logic [7:0] ad_host_oe;
  logic [7:0] ad_dev_o;
  logic [7:0] ad_dev_oe;
  logic [7:0] ad;
  logic int_oe;
  logic int_n;
  // Wire resolution, pull-up on the interrupt line
  assign ad = ad_host_oe[0] ? ad_host_o : (ad_dev_oe[0] ? ad_dev_o : 8'hFF);
  assign int_n = int_oe ? 1'b0 : 1'b1;
  modport dev (input ale, rd_n, wr_n, cs_n, ad, output ad_dev_o, ad_dev_oe, int_oe);
  modport host (output ale, rd_n, wr_n, cs_n, ad_host_o, ad_host_oe, input ad, int_n);
endinterface : hprx_bus_if

// file: design/hprx_device.sv
// Transceiver end: host port, interrupt logic and receive outputs
`timescale 1ns/1ps
module hprx_device
  import hprx_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // Bus style strap
  input wire hprx_pkg::hprx_style_t bus_style,
  // Host bus
  hprx_bus_if.dev bus,
  // Receive path from the recovery logic
  input wire logic line_pos_pulse,
  input wire logic line_neg_pulse,
  input wire logic line_violation,
  input wire logic recovered_clk_en,
  input wire logic master_clk_en,
  // Monitor status sources
  input wire logic [hprx_pkg::SRC_W-1:0] status_src,
  // Receive outputs
  output logic rx_positive_rail,
  output logic rx_negative_rail,
  output logic line_code_violation,
  output logic rx_clk_out
);
  import hprx_pkg::*;

  logic [7:0] addr_ff;
  logic [7:0] control_reg_three_ff;
  logic [SRC_W-1:0] interrupt_clear_reg_ff;
  logic [SRC_W-1:0] src_prev_ff;
  logic [SRC_W-1:0] pend_ff;
  logic [7:0] ad_o_ff;
  logic ad_oe_ff;
  logic int_oe_ff;
  logic ale_d_ff;
  logic wstb_d_ff;
  logic rd_act;
  logic wstb;
  logic wr_edge;
  logic [SRC_W-1:0] chg;
  logic [7:0] rd_val;
  logic clk_src_ff;
  logic rclk_ff;
  logic pos_ff;
  logic neg_ff;
  logic viol_ff;

  // Strobe decoding for both styles
  always_comb begin
    if (bus_style == HPRX_SEP_STROBE) begin
      rd_act = !bus.rd_n;
      wstb = !bus.wr_n;
    end else begin
      rd_act = !bus.rd_n && bus.wr_n;
      wstb = !bus.rd_n && !bus.wr_n;
    end
  end

  // Write taken on the trailing edge of the strobe, only while selected
  assign wr_edge = wstb_d_ff && !wstb && !bus.cs_n;

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      wstb_d_ff <= 1'b0;
      ale_d_ff <= 1'b0;
    end else begin
      wstb_d_ff <= wstb && !bus.cs_n;
      ale_d_ff <= bus.ale;
    end
  end

  // Address held from latch fall until next latch
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      addr_ff <= 8'h00;
    end else if (ale_d_ff && !bus.ale && !bus.cs_n) begin
      addr_ff <= bus.ad;
    end
  end

  // Control and clear registers
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      control_reg_three_ff <= CTRL_RST;
      interrupt_clear_reg_ff <= CLEAR_RST[SRC_W-1:0];
    end else if (wr_edge) begin
      if (addr_ff == CTRL_THREE_ADDR) begin
        control_reg_three_ff <= bus.ad;
      end
      if (addr_ff == CLEAR_ADDR) begin
        interrupt_clear_reg_ff <= bus.ad[SRC_W-1:0];
      end
    end
  end

  // Read mux, unmapped reads as zero
  always_comb begin
    case (addr_ff)
      CTRL_THREE_ADDR: rd_val = control_reg_three_ff;
      STATUS_ADDR: rd_val = {2'b00, status_src};
      CLEAR_ADDR: rd_val = {2'b00, interrupt_clear_reg_ff};
      PEND_ADDR: rd_val = {2'b00, pend_ff};
      default: rd_val = RDATA_RST;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      ad_o_ff <= RDATA_RST;
      ad_oe_ff <= 1'b0;
    end else begin
      ad_o_ff <= rd_val;
      ad_oe_ff <= rd_act && !bus.cs_n && !bus.ale;
    end
  end

  assign bus.ad_dev_o = ad_o_ff;
  assign bus.ad_dev_oe = {8{ad_oe_ff}};

  // Change detection; the elastic store bit is an event level, so any edge counts
  assign chg = status_src ^ src_prev_ff;

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      src_prev_ff <= '0;
      pend_ff <= '0;
    end else begin
      src_prev_ff <= status_src;
      // Masked sources are held clear; a fresh change still needs unmask
      pend_ff <= (pend_ff | chg) & ~interrupt_clear_reg_ff;
    end
  end

  // Open drain: only ever enables a low drive
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      int_oe_ff <= 1'b0;
    end else begin
      int_oe_ff <= |pend_ff;
    end
  end

  assign bus.int_oe = int_oe_ff;

  // Clock source swaps only while the output clock rclk_ff is low, so no runt pulse
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      clk_src_ff <= 1'b0;
      rclk_ff <= 1'b0;
    end else begin
      if (!rclk_ff) begin
        clk_src_ff <= status_src[SRC_NOSIG];
      end
      rclk_ff <= clk_src_ff ? master_clk_en : recovered_clk_en;
    end
  end

  // Data changes on the edge opposite the sampling edge chosen
  logic upd;
  assign upd = control_reg_three_ff[CTRL_EDGE_BIT] ? (!rclk_ff && recovered_clk_en)
                                                  : (rclk_ff && !recovered_clk_en);
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      pos_ff <= 1'b0;
      neg_ff <= 1'b0;
      viol_ff <= 1'b0;
    end else begin
      if (upd) begin
        if (control_reg_three_ff[CTRL_UNIPOLAR_BIT]) begin
          pos_ff <= line_pos_pulse || line_neg_pulse;
        end else begin
          pos_ff <= line_pos_pulse;
          neg_ff <= line_neg_pulse;
        end
      end
      // Violation always changes on falling clock so it is valid at rise
      if (rclk_ff && !recovered_clk_en) begin
        viol_ff <= control_reg_three_ff[CTRL_UNIPOLAR_BIT] && line_violation;
        // Rail carries the flag in unipolar mode, still straight from a flop
        if (control_reg_three_ff[CTRL_UNIPOLAR_BIT]) begin
          neg_ff <= line_violation;
        end
      end
    end
  end

  assign rx_positive_rail = pos_ff;
  assign rx_negative_rail = neg_ff;
  assign line_code_violation = viol_ff;
  assign rx_clk_out = rclk_ff;
endmodule : hprx_device

// file: design/hprx_host.sv
// Host end: drives multiplexed bus cycles in either style
`timescale 1ns/1ps
module hprx_host
  import hprx_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // Bus style strap
  input wire hprx_pkg::hprx_style_t bus_style,
  // User request
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic [7:0] req_addr,
  input wire logic [7:0] req_wdata,
  output logic req_ready,
  output logic resp_valid,
  output logic [7:0] resp_rdata,
  output logic irq,
  // Host bus
  hprx_bus_if.host bus
);
  import hprx_pkg::*;

  typedef enum logic [2:0] {HS_IDLE, HS_ADDR, HS_GAP, HS_DATA, HS_END} hprx_hstate_t;
  hprx_hstate_t st_ff;
  logic [2:0] cnt_ff;
  logic wr_ff;
  logic [7:0] addr_ff;
  logic [7:0] wdata_ff;
  logic ale_ff;
  logic rd_n_ff;
  logic wr_n_ff;
  logic cs_n_ff;
  logic [7:0] ad_o_ff;
  logic ad_oe_ff;
  logic ready_ff;
  logic rv_ff;
  logic [7:0] rdata_ff;
  logic irq_ff;

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      st_ff <= HS_IDLE;
      cnt_ff <= 3'h0;
      wr_ff <= 1'b0;
      addr_ff <= 8'h00;
      wdata_ff <= 8'h00;
      ale_ff <= 1'b0;
      rd_n_ff <= 1'b1;
      wr_n_ff <= 1'b1;
      cs_n_ff <= 1'b1;
      ad_o_ff <= 8'h00;
      ad_oe_ff <= 1'b0;
      ready_ff <= 1'b0;
      rv_ff <= 1'b0;
      rdata_ff <= 8'h00;
    end else begin
      rv_ff <= 1'b0;
      ready_ff <= 1'b0;
      cnt_ff <= cnt_ff - 3'h1;
      case (st_ff)
        HS_IDLE: begin
          ready_ff <= 1'b1;
          if (req_valid && ready_ff) begin
            ready_ff <= 1'b0;
            wr_ff <= req_write;
            addr_ff <= req_addr;
            wdata_ff <= req_wdata;
            cs_n_ff <= 1'b0;
            ale_ff <= 1'b1;
            ad_o_ff <= req_addr;
            ad_oe_ff <= 1'b1;
            cnt_ff <= STROBE_CNT;
            st_ff <= HS_ADDR;
          end
        end
        HS_ADDR: begin
          if (cnt_ff == 3'h0) begin
            // Address stays driven past the latch fall; the device takes it a cycle later
            ale_ff <= 1'b0;
            cnt_ff <= STROBE_CNT;
            st_ff <= HS_GAP;
          end
        end
        HS_GAP: begin
          if (cnt_ff == 3'h0) begin
            ad_o_ff <= wdata_ff;
            ad_oe_ff <= wr_ff;
            if (bus_style == HPRX_SEP_STROBE) begin
              rd_n_ff <= wr_ff;
              wr_n_ff <= !wr_ff;
            end else begin
              rd_n_ff <= 1'b0;
              wr_n_ff <= !wr_ff;
            end
            cnt_ff <= STROBE_CNT;
            st_ff <= HS_DATA;
          end
        end
        HS_DATA: begin
          if (cnt_ff == 3'h0) begin
            rdata_ff <= bus.ad;
            rd_n_ff <= 1'b1;
            wr_n_ff <= 1'b1;
            cnt_ff <= STROBE_CNT;
            st_ff <= HS_END;
          end
        end
        HS_END: begin
          // Data and select held past the strobe edge for the device sample
          if (cnt_ff == 3'h0) begin
            ad_oe_ff <= 1'b0;
            cs_n_ff <= 1'b1;
            rv_ff <= !wr_ff;
            st_ff <= HS_IDLE;
          end
        end
        default: st_ff <= HS_IDLE;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= !bus.int_n;
    end
  end

  assign bus.ale = ale_ff;
  assign bus.rd_n = rd_n_ff;
  assign bus.wr_n = wr_n_ff;
  assign bus.cs_n = cs_n_ff;
  assign bus.ad_host_o = ad_o_ff;
  assign bus.ad_host_oe = {8{ad_oe_ff}};
  assign req_ready = ready_ff;
  assign resp_valid = rv_ff;
  assign resp_rdata = rdata_ff;
  assign irq = irq_ff;
endmodule : hprx_host

// file: bench/hprx_bus_monitor.sv
// Checker on the shared host bus and interrupt line
`timescale 1ns/1ps
module hprx_bus_monitor (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // Bus lines
  input wire logic ale,
  input wire logic rd_n,
  input wire logic cs_n,
  input wire logic [7:0] ad_host_oe,
  input wire logic [7:0] ad_dev_oe,
  input wire logic int_oe,
  input wire logic int_n
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  a_idle_no_drive: assert property (cs_n && $past(cs_n) |-> !ad_dev_oe[0])
    else $error("device drives bus while deselected");
  a_no_contention: assert property (!(ad_host_oe[0] && ad_dev_oe[0]))
    else $error("both ends drive the bus");
  a_latch_quiet: assert property (ale |-> !ad_dev_oe[0])
    else $error("device drives during address phase");
  a_int_open_drain: assert property (int_n == !int_oe)
    else $error("interrupt line level wrong");
  a_read_on_strobe: assert property ($rose(ad_dev_oe[0]) |-> !rd_n && !cs_n)
    else $error("read data without strobe");
  a_addr_first: assert property ($fell(cs_n) |-> ale && ad_host_oe[0])
    else $error("access lacks address phase");
  a_select_held: assert property ($fell(cs_n) |-> !cs_n [*8])
    else $error("select dropped early");
  a_access_bound: assert property ($fell(cs_n) |-> ##[15:25] $rose(cs_n))
    else $error("access length out of range");
  // Strobe on rd_n must end before select does, or the device misses it
  a_strobe_inside: assert property ($rose(cs_n) |-> rd_n)
    else $error("strobe outlives select");
  c_read: cover property ($rose(ad_dev_oe[0]));
  c_irq: cover property ($fell(int_n));
  c_access: cover property ($rose(cs_n));
endmodule : hprx_bus_monitor

// file: bench/host_port_and_rx_outputs_test.sv
// Bench joining host end and device end on one bus
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin n_mismatch++; \
  $display("[FAIL] %s exp %h got %h", nm, ex, got); end end
module host_port_and_rx_outputs_test;
  import hprx_pkg::*;
  logic core_clk = 0, rstn = 0, req_valid = 0, req_write = 0, run_rclk = 1;
  logic req_ready, resp_valid, irq, rx_positive_rail, rx_negative_rail;
  logic line_code_violation, rx_clk_out;
  logic line_pos_pulse = 0, line_neg_pulse = 0, line_violation = 0;
  logic recovered_clk_en = 0, master_clk_en = 0;
  logic [7:0] req_addr = 8'h00, req_wdata = 8'h00, resp_rdata, q;
  logic [5:0] status_src = 6'h00;
  logic [31:0] seed = 32'hDDCB;
  hprx_style_t bus_style = HPRX_SEP_STROBE;
  int n_mismatch = 0, checked = 0, toggles;
  hprx_bus_if bus ();
  hprx_device hprx_device_inst (.core_clk, .rstn, .bus_style, .bus(bus), .line_pos_pulse,
    .line_neg_pulse, .line_violation, .recovered_clk_en, .master_clk_en, .status_src,
    .rx_positive_rail, .rx_negative_rail, .line_code_violation, .rx_clk_out);
  hprx_host hprx_host_inst (.core_clk, .rstn, .bus_style, .req_valid, .req_write, .req_addr,
    .req_wdata, .req_ready, .resp_valid, .resp_rdata, .irq, .bus(bus));
  hprx_bus_monitor hprx_bus_monitor_inst (.core_clk, .rstn, .ale(bus.ale), .rd_n(bus.rd_n),
    .cs_n(bus.cs_n), .ad_host_oe(bus.ad_host_oe), .ad_dev_oe(bus.ad_dev_oe),
    .int_oe(bus.int_oe), .int_n(bus.int_n));
  always #25 core_clk = ~core_clk;
  // Slow clocks as level enables; recovered one stops on signal loss
  always @(negedge core_clk) begin
    master_clk_en <= ~master_clk_en;
    recovered_clk_en <= run_rclk & ~recovered_clk_en;
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction : xs
  task automatic report_and_stop();
    if (n_mismatch == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : report_and_stop
  // One bus access; ends on a falling edge so callers drive there
  task automatic xfer(input int w, input logic [7:0] a, input logic [7:0] d);
    int i;
    q = 8'hXX;
    for (i = 0; req_ready !== 1'b1; i++) begin
      if (i > 60) begin n_mismatch++; report_and_stop(); end
      @(negedge core_clk);
    end
    req_valid = 1;
    req_write = w[0];
    req_addr = a;
    req_wdata = d;
    @(negedge core_clk);
    req_valid = 0;
    i = 0;
    do begin
      @(posedge core_clk);
      #1;
      if (resp_valid === 1'b1) q = resp_rdata;
      i++;
    end while (req_ready !== 1'b1 && i < 60);
    if (i >= 60) begin n_mismatch++; report_and_stop(); end
    @(negedge core_clk);
  endtask : xfer
  initial begin
    repeat (3) @(negedge core_clk);
    rstn = 1;
    for (int s = 0; s < 2; s++) begin
      bus_style = hprx_style_t'(s);
      for (int k = 0; k < 3; k++) begin
        seed = xs(seed);
        xfer(1, 8'h03, {6'h00, seed[1:0]});
        xfer(0, 8'h03, 8'h00);
        `CHK("ctrl", {6'h00, seed[1:0]}, q)
        status_src = seed[13:8];
        xfer(0, 8'h10, 8'h00);
        `CHK("status", {2'b00, status_src}, q)
        xfer(0, 8'h55, 8'h00);
        `CHK("unmapped", 8'h00, q)
      end
    end
    xfer(1, 8'h11, 8'h3F);
    `CHK("irq masked", 1'b0, irq)
    xfer(1, 8'h11, 8'h00);
    for (int b = 0; b < 6; b++) begin
      status_src[b] = ~status_src[b];
      repeat (5) @(negedge core_clk);
      `CHK("irq set", 1'b1, irq)
      xfer(0, 8'h12, 8'h00);
      `CHK("pending", 8'h01 << b, q)
      xfer(1, 8'h11, 8'h01 << b);
      `CHK("irq clear", 1'b0, irq)
      status_src[b] = ~status_src[b];
      repeat (5) @(negedge core_clk);
      `CHK("irq blocked", 1'b0, irq)
      xfer(1, 8'h11, 8'h00);
      `CHK("irq reenabled", 1'b0, irq)
    end
    for (int k = 0; k < 8; k++) begin
      seed = xs(seed);
      xfer(1, 8'h03, {6'h00, k[2], seed[0]});
      line_pos_pulse = seed[1];
      line_neg_pulse = seed[2] & ~seed[1];
      line_violation = seed[3];
      for (int c = 0; c < 12; c++) begin
        q[0] = rx_positive_rail;
        @(negedge core_clk);
        if (q[0] !== rx_positive_rail) `CHK("rail edge", seed[0], rx_clk_out)
      end
      if (k < 4) begin
        `CHK("pos rail", line_pos_pulse, rx_positive_rail)
        `CHK("neg rail", line_neg_pulse, rx_negative_rail)
      end else begin
        `CHK("data", line_pos_pulse | line_neg_pulse, rx_positive_rail)
        `CHK("violation", line_violation, line_code_violation)
        `CHK("viol rail", line_violation, rx_negative_rail)
      end
    end
    status_src[0] = 1'b0;
    repeat (4) @(negedge core_clk);
    run_rclk = 0;
    status_src[0] = 1'b1;
    repeat (4) @(negedge core_clk);
    toggles = 0;
    repeat (20) begin
      q[0] = rx_clk_out;
      @(negedge core_clk);
      toggles += int'(q[0] !== rx_clk_out);
    end
    `CHK("master clock", 1'b1, toggles > 8)
    report_and_stop();
  end
endmodule : host_port_and_rx_outputs_test
